// ==== logic/msps_supervisor.sv ====
`timescale 1ns/100ps
module msps_supervisor
  import msps_pkg::*;
#(
  parameter int SEC_CYCLES = msps_pkg::SEC_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] current_i,
  input  wire logic        full_voltage_i,
  input  wire logic        phase_ok_i,
  input  wire logic        thyr_hot_i,
  input  wire logic        jog_input,
  input  wire logic        reset_input,
  output logic             motor_on,
  output logic      [7:0]  volt_ref,
  output logic      [15:0] current_cap,
  output logic             brake_relay,
  output logic             overload_en,
  output logic             pump_mode_message,
  output logic      [7:0]  fault_code,
  output logic             start_blocked
);
  import msps_pkg::*;

  // ========================================================
  // Pin synchronisers
  logic [4:0] pins_s;
  msps_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d       ({reset_input, jog_input, thyr_hot_i, phase_ok_i,
               full_voltage_i}),
    .q       (pins_s)
  );
  wire full_s = pins_s[0];
  wire phase_s = pins_s[1];
  wire hot_s = pins_s[2];
  wire jog_s = pins_s[3];
  wire ext_clr_s = pins_s[4];

  // ========================================================
  // Registers
  logic [3:0]  ctrl_q;
  logic [7:0]  func_q;
  logic [31:0] time0_q;
  logic [29:0] lim_q;
  logic [31:0] lvl_q;
  logic [23:0] time1_q;
  logic [15:0] rated_q;
  logic        ack_q;

  // Field views
  wire       run_cmd = ctrl_q[C_RUN];
  wire       kick_start_enable = ctrl_q[C_KICK];
  wire       phase_order_check = ctrl_q[C_PHASE];
  wire [3:0] relay_two_function = func_q[3:0];
  wire [3:0] input_four_function = func_q[7:4];
  wire [7:0] accel_ramp_time = time0_q[7:0];
  wire [7:0] decel_ramp_time = time0_q[15:8];
  wire [7:0] overcurrent_time = time0_q[23:16];
  wire [7:0] undercurrent_time = time0_q[31:24];
  wire [9:0] start_current_limit = lim_q[9:0];
  wire [9:0] overcurrent_threshold = lim_q[19:10];
  wire [9:0] undercurrent_threshold = lim_q[29:20];
  wire [7:0] decel_start_level = lvl_q[7:0];
  wire [7:0] jog_voltage_level = lvl_q[15:8];
  wire [7:0] dc_brake_level = lvl_q[23:16];
  wire [7:0] kick_pulse_level = lvl_q[31:24];
  wire [7:0] dc_brake_time = time1_q[7:0];
  wire [7:0] kick_pulse_time = time1_q[15:8];
  wire [7:0] auto_reset_delay = time1_q[23:16];
  wire [15:0] switch_rated_current = rated_q;

  // Bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i;
  wire wr_ctrl = wr && (wb_adr_i == A_CTRL);
  wire [31:0] ctrl_w = msps_lanes({28'h0, ctrl_q}, wb_dat_i, wb_sel_i);
  // Merged write words for the narrow registers
  wire [31:0] func_w = msps_lanes({24'h0, func_q}, wb_dat_i, wb_sel_i);
  wire [31:0] lim_w = msps_lanes({2'h0, lim_q}, wb_dat_i, wb_sel_i);
  wire [31:0] time1_w = msps_lanes({8'h0, time1_q}, wb_dat_i, wb_sel_i);
  wire [31:0] rated_w = msps_lanes({16'h0, rated_q}, wb_dat_i, wb_sel_i);
  wire pump_load = wr_ctrl && ctrl_w[C_PUMP];
  wire man_clr = wr_ctrl && ctrl_w[C_CLR];

  // ========================================================
  // Seconds tick and state timers
  logic [26:0] sec_cnt_q;
  logic        tick_q;
  logic [7:0]  st_sec_q;
  logic [7:0]  since_q;
  logic [7:0]  kick_q;
  wire         sec_end = (sec_cnt_q == 27'(SEC_CYCLES - 1));

  // ========================================================
  // Fault and state signals
  msps_state_t st_q;
  msps_state_t st_d;
  logic [7:0]  fault_q;
  logic [7:0]  last_q;
  logic [1:0]  rep_q;
  logic        blocked_q;
  logic        auto_last_q;
  logic        ph_ok_q;
  logic [1:0]  ph_wait_q;
  logic        oc_trip;
  logic        uc_trip;
  logic [7:0]  fault_d;

  // Thresholds in amperes
  wire [15:0] lim_a = msps_scale(start_current_limit,
                                 switch_rated_current);
  wire [15:0] oc_a = msps_scale(overcurrent_threshold,
                                switch_rated_current);
  wire [15:0] uc_a = msps_scale(undercurrent_threshold,
                                switch_rated_current);

  // Trip arming only at full voltage after start
  wire armed = (st_q == ST_RUN) && full_s;
  wire oc_cond = armed && (overcurrent_threshold != 10'h0) &&
                 (current_i > oc_a);
  wire uc_cond = armed && (undercurrent_threshold != 10'h0) &&
                 (current_i < uc_a);

  msps_trip_timer #(.W(8)) u_oc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cond    (oc_cond),
    .tick    (tick_q),
    .limit   (overcurrent_time),
    .strict  (1'b1),
    .trip    (oc_trip)
  );

  msps_trip_timer #(.W(8)) u_uc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cond    (uc_cond),
    .tick    (tick_q),
    .limit   (undercurrent_time),
    .strict  (1'b0),
    .trip    (uc_trip)
  );

  // Sequencing terms
  wire ramp_exp = (st_sec_q >= accel_ramp_time);
  wire brake_ok = (relay_two_function == BRAKE_FN) &&
                  (dc_brake_time != 8'h00);
  wire jog_ok = (input_four_function == JOG_FN);
  wire clr_req = man_clr || ext_clr_s;
  wire auto_go = (auto_reset_delay != 8'h00) && msps_auto_ok(fault_q) &&
                 (st_sec_q >= auto_reset_delay);
  wire fault_hit = (fault_d != F_NONE);
  wire repeat_hit = fault_hit && auto_last_q && (fault_d == last_q) &&
                    (since_q <= REP_WIN);
  wire ph_done = (ph_wait_q == 2'h3);
  wire stopped_ramp = (decel_ramp_time != 8'h00);

  // Fault detection, thermal first
  always_comb begin
    fault_d = F_NONE;
    if (st_q != ST_FAULT) begin
      if (hot_s) begin
        fault_d = F_THERM;
      end else if (st_q == ST_IDLE && run_cmd && phase_order_check &&
                   !ph_ok_q) begin
        fault_d = F_PHASE;
      end else if (st_q == ST_ACCEL && !full_s && ramp_exp) begin
        fault_d = F_ACC;
      end else if (st_q == ST_JOG && ramp_exp) begin
        fault_d = F_ACC;
      end else if (oc_trip && armed) begin
        fault_d = F_OC;
      end else if (uc_trip && armed) begin
        fault_d = F_UC;
      end
    end
  end

  // Next state
  always_comb begin
    st_d = st_q;
    if (fault_hit) begin
      st_d = ST_FAULT;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (run_cmd && ph_done) begin
            st_d = ST_ACCEL;
          end else if (jog_s && jog_ok && ph_done) begin
            st_d = ST_JOG;
          end
        end
        ST_ACCEL: begin
          if (full_s) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_cmd) begin
            st_d = brake_ok ? ST_BRAKE :
                   (stopped_ramp ? ST_DECEL : ST_IDLE);
          end
        end
        ST_DECEL: begin
          if (st_sec_q >= decel_ramp_time) begin
            st_d = brake_ok ? ST_BRAKE : ST_IDLE;
          end
        end
        ST_BRAKE: begin
          if (st_sec_q >= dc_brake_time) begin
            st_d = ST_IDLE;
          end
        end
        ST_JOG: begin
          if (!jog_s) begin
            st_d = stopped_ramp ? ST_DECEL : ST_IDLE;
          end
        end
        ST_FAULT: begin
          if (!blocked_q && (clr_req || auto_go)) begin
            st_d = ST_IDLE;
          end
        end
      endcase
    end
  end

  // ========================================================
  // Register writes and pump presets
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= R_CTRL;
      func_q  <= R_FUNC;
      time0_q <= R_TIME0;
      lim_q   <= R_LIM;
      lvl_q   <= R_LVL;
      time1_q <= R_TIME1;
      rated_q <= R_RATED;
      pump_mode_message <= 1'b0;
    end else if (ce && wr) begin
      unique case (wb_adr_i)
        A_CTRL: begin
          ctrl_q <= ctrl_w[3:0];
          pump_mode_message <= ctrl_w[C_PUMP];
          if (pump_load) begin
            time0_q[15:0]  <= {PRE_DEC, PRE_ACC};
            time0_q[31:24] <= PRE_UCT;
            lim_q[9:0]     <= PRE_LIM;
            lim_q[29:20]   <= PRE_UCL;
            lvl_q[7:0]     <= PRE_DSL;
          end
        end
        A_FUNC: func_q <= func_w[7:0];
        A_TIME0: time0_q <= msps_lanes(time0_q, wb_dat_i, wb_sel_i);
        A_LIM: lim_q <= lim_w[29:0];
        A_LVL: lvl_q <= msps_lanes(lvl_q, wb_dat_i, wb_sel_i);
        A_TIME1: time1_q <= time1_w[23:0];
        A_RATED: rated_q <= rated_w[15:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped reads zero
  logic [31:0] rd_d;
  always_comb begin
    unique case (wb_adr_i)
      A_CTRL:  rd_d = {28'h0, ctrl_q};
      A_FUNC:  rd_d = {24'h0, func_q};
      A_TIME0: rd_d = time0_q;
      A_LIM:   rd_d = {2'h0, lim_q};
      A_LVL:   rd_d = lvl_q;
      A_TIME1: rd_d = {8'h0, time1_q};
      A_RATED: rd_d = {16'h0, rated_q};
      A_STAT:  rd_d = {13'h0, blocked_q, ph_ok_q, rep_q, st_q, fault_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus answer, one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      ack_q    <= req;
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h0000_0000;
    end
  end

  // ========================================================
  // Timebase, state timer and kick pulse counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sec_cnt_q <= 27'h0;
      tick_q    <= 1'b0;
      st_sec_q  <= 8'h00;
      since_q   <= 8'hff;
      kick_q    <= 8'h00;
    end else if (ce) begin
      sec_cnt_q <= sec_end ? 27'h0 : sec_cnt_q + 27'h1;
      tick_q    <= sec_end;
      if (st_d != st_q) begin
        st_sec_q <= 8'h00;
      end else if (tick_q && st_sec_q != 8'hff) begin
        st_sec_q <= st_sec_q + 8'h01;
      end
      if (fault_hit) begin
        since_q <= 8'h00;
      end else if (tick_q && since_q != 8'hff) begin
        since_q <= since_q + 8'h01;
      end
      if (st_q == ST_IDLE && st_d == ST_ACCEL) begin
        kick_q <= kick_start_enable ? kick_pulse_time : 8'h00;
      end else if (tick_q && kick_q != 8'h00) begin
        kick_q <= kick_q - 8'h01;
      end
    end
  end

  // ========================================================
  // State, fault latch and recurrence count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      fault_q     <= F_NONE;
      last_q      <= F_NONE;
      rep_q       <= 2'h0;
      blocked_q   <= 1'b0;
      auto_last_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      if (fault_hit) begin
        fault_q <= fault_d;
        last_q  <= fault_d;
        rep_q   <= repeat_hit ? rep_q + 2'h1 : 2'h0;
        blocked_q <= repeat_hit && (rep_q == REP_LAST);
      end else if (st_q == ST_FAULT && st_d == ST_IDLE) begin
        fault_q     <= F_NONE;
        auto_last_q <= !clr_req;
      end
    end
  end

  // Phase order caught once, after the synchroniser has settled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_wait_q <= 2'h0;
      ph_ok_q   <= 1'b0;
    end else if (ce && !ph_done) begin
      ph_wait_q <= ph_wait_q + 2'h1;
      if (ph_wait_q == 2'h2) begin
        ph_ok_q <= phase_s;
      end
    end
  end

  // ========================================================
  // Outputs towards the power stage
  wire on_d = (st_d == ST_ACCEL) || (st_d == ST_RUN) ||
              (st_d == ST_DECEL) || (st_d == ST_JOG);
  logic [7:0] volt_d;
  always_comb begin
    unique case (st_d)
      ST_ACCEL: volt_d = (kick_q != 8'h00) ? kick_pulse_level
                                           : FULL_PCT;
      ST_RUN:   volt_d = FULL_PCT;
      ST_DECEL: volt_d = decel_start_level;
      ST_JOG:   volt_d = jog_voltage_level;
      ST_BRAKE: volt_d = dc_brake_level;
      default:  volt_d = 8'h00;
    endcase
  end
  wire lim_on = (st_d == ST_ACCEL) && (start_current_limit != 10'h0) &&
                !kick_start_enable;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      motor_on      <= 1'b0;
      volt_ref      <= 8'h00;
      current_cap   <= 16'hffff;
      brake_relay   <= 1'b0;
      overload_en   <= 1'b1;
      fault_code    <= F_NONE;
      start_blocked <= 1'b0;
    end else if (ce) begin
      motor_on      <= on_d && !fault_hit;
      volt_ref      <= fault_hit ? 8'h00 : volt_d;
      current_cap   <= lim_on ? lim_a : 16'hffff;
      brake_relay   <= (st_d == ST_BRAKE);
      overload_en   <= (st_d != ST_BRAKE);
      fault_code    <= fault_hit ? fault_d : fault_q;
      start_blocked <= blocked_q;
    end
  end

  // ========================================================
  // Checks
  a_accel_timeout: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && st_q == ST_ACCEL && ramp_exp && !full_s && !hot_s)
    |=> (st_q == ST_FAULT) && (fault_q == F_ACC))
    else $error("acceleration timeout not raised");

  a_thermal_trip: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && hot_s && st_q != ST_FAULT)
    |=> fault_q == F_THERM ##1 !motor_on)
    else $error("thermal trip missed");

  a_limit_kick: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && kick_start_enable) |=> current_cap == 16'hffff)
    else $error("current limit active with kick start");

  a_trip_armed: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && st_q != ST_RUN && st_q != ST_FAULT)
    |=> !(fault_q == F_OC || fault_q == F_UC))
    else $error("current trip while not at full voltage");

  a_brake_cfg: assert property (@(posedge ref_clk)
    disable iff (rst)
    brake_relay |-> $past(relay_two_function) == BRAKE_FN
                    && !overload_en)
    else $error("braking without relay two code");

  a_jog_cfg: assert property (@(posedge ref_clk)
    disable iff (rst)
    (st_q == ST_JOG) |-> $past(input_four_function) == JOG_FN
                         || $past(st_q) == ST_JOG)
    else $error("jog without input four code");

  a_pump_preset: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && pump_load) |=> accel_ramp_time == PRE_ACC &&
    undercurrent_time == PRE_UCT && pump_mode_message)
    else $error("pump presets not loaded");

  a_auto_off: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && st_q == ST_FAULT && auto_reset_delay == 8'h00 && !clr_req)
    |=> st_q == ST_FAULT)
    else $error("auto reset while disabled");

  a_blocked_hold: assert property (@(posedge ref_clk)
    disable iff (rst)
    blocked_q |=> st_q == ST_FAULT && !motor_on)
    else $error("blocked supervisor left fault");
endmodule

// ==== logic/msps_pkg.sv ====
package msps_pkg;

  // ==========================================================
  // Timing
  localparam int SEC_NS  = 1_000_000_000;
  localparam int CLK_NS  = 10;
  localparam int SEC_CYC = SEC_NS / CLK_NS;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_FUNC  = 8'h04;
  localparam logic [7:0] A_TIME0 = 8'h08;
  localparam logic [7:0] A_LIM   = 8'h0c;
  localparam logic [7:0] A_LVL   = 8'h10;
  localparam logic [7:0] A_TIME1 = 8'h14;
  localparam logic [7:0] A_RATED = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h1c;

  // Control bit positions
  localparam int C_RUN   = 0;
  localparam int C_KICK  = 1;
  localparam int C_PHASE = 2;
  localparam int C_PUMP  = 3;
  localparam int C_CLR   = 4;

  // Reset values
  localparam logic [3:0]  R_CTRL  = 4'h0;
  localparam logic [7:0]  R_FUNC  = 8'h00;
  localparam logic [31:0] R_TIME0 = 32'h0005_0a0a;
  localparam logic [29:0] R_LIM   = 30'h0000_0000;
  localparam logic [31:0] R_LVL   = 32'h0000_1e50;
  localparam logic [23:0] R_TIME1 = 24'h00_0000;
  localparam logic [15:0] R_RATED = 16'h0064;

  // ==========================================================
  // Function codes, pump presets, recurrence limits
  localparam logic [3:0] JOG_FN   = 4'h4;
  localparam logic [3:0] BRAKE_FN = 4'h3;
  localparam logic [7:0] PRE_ACC  = 8'h0f;
  localparam logic [7:0] PRE_DSL  = 8'h50;
  localparam logic [7:0] PRE_DEC  = 8'h0f;
  localparam logic [9:0] PRE_LIM  = 10'h000;
  localparam logic [9:0] PRE_UCL  = 10'h046;
  localparam logic [7:0] PRE_UCT  = 8'h05;
  localparam logic [7:0] REP_WIN  = 8'h3c;
  localparam logic [1:0] REP_LAST = 2'h2;
  localparam logic [7:0] FULL_PCT = 8'h64;

  // Fault codes
  localparam logic [7:0] F_NONE  = 8'h00;
  localparam logic [7:0] F_EX1   = 8'h01;
  localparam logic [7:0] F_ACC   = 8'h02;
  localparam logic [7:0] F_PHASE = 8'h03;
  localparam logic [7:0] F_THERM = 8'h04;
  localparam logic [7:0] F_UC    = 8'h05;
  localparam logic [7:0] F_OC    = 8'h06;
  localparam logic [7:0] F_EX7   = 8'h07;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ACCEL = 7'h02,
    ST_RUN   = 7'h04,
    ST_DECEL = 7'h08,
    ST_BRAKE = 7'h10,
    ST_JOG   = 7'h20,
    ST_FAULT = 7'h40
  } msps_state_t;

  // Percent of rated current to amperes
  function automatic logic [15:0] msps_scale(input logic [9:0] pct,
                                             input logic [15:0] rated);
    logic [25:0] p;
    logic [25:0] q;
    p = {16'h0000, pct} * {10'h000, rated};
    q = p / 26'd100;
    return q[15:0];
  endfunction

  // Faults that may clear themselves
  function automatic logic msps_auto_ok(input logic [7:0] code);
    return !(code == F_ACC || code == F_EX1 || code == F_EX7 ||
             code[7:4] == 4'h2);
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] msps_lanes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ==== logic/msps_sync.sv ====
`timescale 1ns/100ps
module msps_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ==== logic/msps_trip_timer.sv ====
`timescale 1ns/100ps
module msps_trip_timer #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         cond,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  input  wire logic         strict,
  output logic              trip
);
  logic [W-1:0] cnt_q;
  wire          sat = &cnt_q;
  wire          over = strict ? (cnt_q > limit) : (cnt_q >= limit);

  // Seconds under condition, restarted when it clears; zero limit is off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      trip  <= 1'b0;
    end else if (ce) begin
      if (!cond) begin
        cnt_q <= '0;
      end else if (tick && !sat) begin
        cnt_q <= cnt_q + 1'b1;
      end
      trip <= cond && (limit != '0) && over;
    end
  end

  a_timer_restart: assert property (@(posedge ref_clk)
    disable iff (rst) (ce && !cond) |=> !trip)
    else $error("trip timer did not restart");
endmodule

// ==== tb/msps_stage_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Power stage: full voltage after a fixed ramp, current only while firing
module msps_stage_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        motor_on,
  input  wire logic        slow,
  input  wire logic [15:0] load,
  output logic             full_voltage_i,
  output logic      [15:0] current_i,
  output logic             phase_ok_i
);
  logic [5:0] ramp_q;
  // Ramp counter restarts whenever firing stops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp_q <= 6'h00;
    end else if (!motor_on) begin
      ramp_q <= 6'h00;
    end else if (ramp_q != 6'h3f) begin
      ramp_q <= ramp_q + 6'h01;
    end
  end
  // A slow stage never reaches full voltage
  assign full_voltage_i = motor_on && !slow && (ramp_q >= 6'h1e);
  assign current_i      = motor_on ? load : 16'h0000;
  assign phase_ok_i     = 1'b1;
endmodule

// ==== tb/tb_motor_start_protection_supervisor.sv ====
`timescale 1ns/100ps
module tb_motor_start_protection_supervisor;
  import msps_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  sel = 4'hf;
  logic [7:0]  adr = 8'h00;
  logic [15:0] load = 16'h0000;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] lf = 32'd68047;
  logic [31:0] wb_dat_o;
  logic [15:0] cur;
  logic [15:0] cap;
  logic [7:0]  fc;
  logic [7:0]  vref;
  logic        hot = 1'b0;
  logic        jog = 1'b0;
  logic        xrst = 1'b0;
  logic        brk, ovl, blk;
  logic        ack, fv, pok, mon, pump;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc_n = 0;

  // ========================================================
  // Clock, design and power stage
  always #5 ref_clk = ~ref_clk;
  msps_supervisor #(.SEC_CYCLES(20)) dut (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
    .current_i(cur), .full_voltage_i(fv), .phase_ok_i(pok),
    .thyr_hot_i(hot), .jog_input(jog), .reset_input(xrst),
    .motor_on(mon), .volt_ref(vref), .current_cap(cap), .brake_relay(brk),
    .overload_en(ovl), .pump_mode_message(pump), .fault_code(fc),
    .start_blocked(blk));
  msps_stage_model stage (
    .ref_clk(ref_clk), .rst(rst), .motor_on(mon), .slow(slow),
    .load(load), .full_voltage_i(fv), .current_i(cur),
    .phase_ok_i(pok));

  // ========================================================
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      stop_test();
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wfault();
    int n;
    n = 0;
    while (fc === 8'h00 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ========================================================
  // Main sequence
  initial begin
    wc(10);
    rst <= 1'b0;
    wc(4);
    wb(0, A_TIME0, 0, 4'hf); chk(rd, 32'h0005_0a0a);
    wb(0, A_LVL, 0, 4'hf); chk(rd, 32'h0000_1e50);
    wb(0, 8'h20, 0, 4'hf); chk(rd, 32'h0000_0000);
    lf = nxt(lf);
    wb(1, A_RATED, lf, 4'h1);
    wb(0, A_RATED, 0, 4'hf); chk(rd, {24'h0, lf[7:0]});
    wb(1, A_RATED, 32'h64, 4'hf);
    wb(1, A_CTRL, 32'h8, 4'hf);
    wc(2); chk(pump, 1'b1);
    wb(0, A_TIME0, 0, 4'hf); chk(rd, 32'h0505_0f0f);
    wb(0, A_LIM, 0, 4'hf); chk(rd, 32'h0460_0000);
    // Accel 3 s, overcurrent 150 % for 1 s, limit 200 %
    wb(1, A_TIME0, 32'h0501_0f03, 4'hf);
    wb(1, A_LIM, 32'h0002_58c8, 4'hf);
    slow <= 1'b1;
    load <= 16'd200 + lf[5:0];
    wb(1, A_CTRL, 32'h1, 4'hf);
    wc(8); chk(cap, 16'h00c8);
    wfault(); chk(fc, 8'h02);
    wc(2); chk(mon, 1'b0);
    wc(80); chk(fc, 8'h02);
    wb(1, A_CTRL, 32'h10, 4'hf);
    wc(2); chk(fc, 8'h00);
    wb(1, A_CTRL, 32'h3, 4'hf);
    wc(8); chk(cap, 16'hffff);
    wfault(); chk(fc, 8'h02);
    wb(1, A_CTRL, 32'h10, 4'hf);
    // Running overcurrent trip, auto-reset after 2 s
    wb(1, A_TIME1, 32'h0002_0000, 4'hf);
    slow <= 1'b0;
    lf = nxt(lf);
    load <= 16'd50 + lf[4:0];
    wb(1, A_CTRL, 32'h1, 4'hf);
    wc(100); chk(fc, 8'h00);
    load <= 16'd151 + lf[12:5];
    wfault(); chk(fc, 8'h06);
    wc(2); chk(mon, 1'b0);
    load <= 16'd60;
    wc(70); chk(fc, 8'h00);
    // Thermal trip after the automatic restart, cleared by the reset pin
    hot <= 1'b1;
    wc(4);
    chk(fc, 8'h04);
    hot <= 1'b0;
    xrst <= 1'b1;
    wc(5);
    chk(fc, 8'h00);
    xrst <= 1'b0;
    // Stop into DC braking, then jog until the ramp time runs out
    wb(1, A_FUNC, 32'h43, 4'hf);
    wb(1, A_LVL, 32'h0028_1e50, 4'hf);
    wb(1, A_TIME1, 32'h0002_0001, 4'hf);
    wc(40);
    wb(1, A_CTRL, 32'h0, 4'hf);
    chk(brk, 1'b1);
    chk(ovl, 1'b0);
    chk(vref, 8'h28);
    jog <= 1'b1;
    wc(30);
    chk(vref, 8'h1e);
    wfault();
    chk(fc, 8'h02);
    chk(mon, 1'b0);
    jog <= 1'b0;
    xrst <= 1'b1;
    wc(5);
    chk(fc, 8'h00);
    xrst <= 1'b0;
    wc(4);
    // Same thermal fault four times inside the window blocks starts
    repeat (4) begin
      hot <= 1'b1;
      wc(4);
      hot <= 1'b0;
      wc(50);
    end
    chk(blk, 1'b1);
    chk(fc, 8'h04);
    stop_test();
  end
endmodule
